// file: rtl/bdc_batch_ctrl.sv
// Batch dispense controller top: counts flow pulses toward a batch and drives two relays.
// Assumes keys are one-cycle pulses and all inputs are synchronous to i_clk.
`timescale 1ns/1ps
`include "bdc_regs.svh"

module bdc_batch_ctrl
  import bdc_pkg::*;
#(
  parameter int CYC_PER_SEC = `BDC_CYC_PER_SEC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Flow and keys
  input wire logic i_flow_pulse,
  input wire logic i_key_run,
  input wire logic i_key_stop,
  input wire logic i_key_reset,
  // Configuration
  input wire logic i_batch_controller_config,
  input wire logic i_qty_load,
  input wire bdc_qty_t i_qty,
  input wire bdc_qty_t i_max_batch_size,
  input wire logic i_auto_restart,
  input wire logic [`BDC_MIN_W-1:0] i_restart_min,
  input wire logic [`BDC_SS_W-1:0] i_restart_sec,
  input wire logic [`BDC_MIN_W-1:0] i_slow_start_min,
  input wire logic [`BDC_SS_W-1:0] i_slow_start_sec,
  input wire bdc_qty_t i_prestop_qty,
  input wire logic i_count_down,
  input wire logic [`BDC_TOUT_W-1:0] i_timeout_sec,
  input wire logic i_overrun_compensation,
  input wire logic i_auto_reset,
  input wire bdc_qty_t i_high_rate_alarm_point,
  input wire bdc_qty_t i_low_rate_alarm_point,
  // Relays
  output logic o_relay1,
  output logic o_relay2,
  // Status
  output bdc_qty_t o_batch_qty,
  output bdc_qty_t o_batch_total,
  output bdc_qty_t o_overrun,
  output logic o_running,
  output logic o_batch_done,
  output logic o_timeout_flag,
  output logic o_qty_reject,
  output logic o_run_refused
);

  // Seconds tick shared with the rate measurement
  bdc_tick_if tick_bus ();
  logic hi_alarm, lo_alarm; // Alarm levels from the rate block

  bdc_state_t state_reg, state_next;   // Sequence state
  logic pulse_prev_reg, pulse_prev_next; // Previous flow input level
  bdc_qty_t qty_reg, qty_next;         // Programmed batch quantity
  bdc_qty_t deliv_reg, deliv_next;     // Quantity delivered in this batch
  bdc_qty_t ovr_cnt_reg, ovr_cnt_next; // Flow seen after the batch ended
  bdc_qty_t comp_reg, comp_next;       // Overrun applied to the next batch
  bdc_sec_t st_sec_reg, st_sec_next;   // Seconds since the state was entered
  bdc_sec_t idle_sec_reg, idle_sec_next; // Seconds since the last flow pulse
  logic need_reset_reg, need_reset_next; // Finished batch not yet cleared
  logic restart_reg, restart_next;     // Re-phase the seconds divider
  logic r1_reg, r1_next, r2_reg, r2_next;
  bdc_qty_t total_reg, total_next;
  logic done_reg, done_next, tout_reg, tout_next;
  logic rej_reg, rej_next, refused_reg, refused_next;
  logic run_reg, run_next; // Running flag, registered so the output is a flop

  // Working terms
  logic edge_seen, run_state, timed_out, idle_like;
  bdc_qty_t target, prestop_pt;

  bdc_sec_timer #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .tick(tick_bus.timer)
  );

  bdc_rate_alarm u_rate (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pulse(edge_seen),
    .i_enable(!i_batch_controller_config),
    .i_high_rate_alarm_point(i_high_rate_alarm_point),
    .i_low_rate_alarm_point(i_low_rate_alarm_point),
    .tick(tick_bus.watch),
    .o_high_alarm(hi_alarm),
    .o_low_alarm(lo_alarm),
    .o_rate()
  );

  assign tick_bus.restart = restart_reg;

  // Sequence, counters and relay values
  always_comb begin
    // Hold by default
    state_next = state_reg;
    pulse_prev_next = i_flow_pulse;
    qty_next = qty_reg;
    deliv_next = deliv_reg;
    ovr_cnt_next = ovr_cnt_reg;
    comp_next = comp_reg;
    st_sec_next = st_sec_reg;
    idle_sec_next = idle_sec_reg;
    need_reset_next = need_reset_reg;
    done_next = done_reg;
    tout_next = tout_reg;
    rej_next = 1'b0;
    refused_next = 1'b0;
    restart_next = 1'b0;

    edge_seen = i_flow_pulse && !pulse_prev_reg;
    run_state = (state_reg == ST_SLOW) || (state_reg == ST_FULL) || (state_reg == ST_PREST);
    idle_like = (state_reg == ST_IDLE) || (state_reg == ST_DONE);
    // Timeout only supervises when set to a nonzero number of seconds
    // Ticks are not aligned to pulses, so one extra tick is needed: a pulse that
    // arrives inside the timeout never trips it, at the cost of up to 1 s late
    timed_out = (i_timeout_sec != `BDC_TIMEOUT_OFF) &&
                (idle_sec_reg > bdc_sec_t'(i_timeout_sec));
    // Batch stops early by the overrun measured after the last one
    target = bdc_sat_sub(qty_reg, comp_reg);
    prestop_pt = bdc_sat_sub(target, i_prestop_qty);

    // Seconds since state entry and since the last pulse, saturating
    if (tick_bus.sec_tick && st_sec_reg != '1) begin
      st_sec_next = st_sec_reg + 1'b1;
    end
    if (edge_seen) begin
      idle_sec_next = '0;
    end else if (tick_bus.sec_tick && idle_sec_reg != '1) begin
      idle_sec_next = idle_sec_reg + 1'b1;
    end

    // Quantity entry only between batches and only in batch configuration
    if (i_qty_load && idle_like && i_batch_controller_config) begin
      if (i_max_batch_size != `BDC_NO_LIMIT && i_qty > i_max_batch_size) begin
        rej_next = 1'b1;
      end else begin
        qty_next = i_qty;
      end
    end

    // Count delivered flow while running, overrun flow once ended
    if (edge_seen && run_state && deliv_reg != '1) begin
      deliv_next = deliv_reg + 1'b1;
    end
    if (edge_seen && state_reg == ST_DONE && ovr_cnt_reg != '1) begin
      ovr_cnt_next = ovr_cnt_reg + 1'b1;
    end

    // Keys between batches; manual reset clears the delivered count
    if (idle_like && i_batch_controller_config) begin
      if (i_key_reset) begin
        deliv_next = '0;
        need_reset_next = 1'b0;
        done_next = 1'b0;
      end else if (i_key_run) begin
        if (need_reset_reg && !i_auto_reset) begin
          refused_next = 1'b1;
        end else begin
          if (need_reset_reg) begin
            deliv_next = '0;
            need_reset_next = 1'b0;
            done_next = 1'b0;
          end
          state_next = ST_SLOW;
          tout_next = 1'b0;
          idle_sec_next = '0;
        end
      end
    end

    case (state_reg)
      ST_IDLE: begin
        // Waiting for run
      end
      ST_SLOW: begin
        // Relay 2 waits out the slow-start time
        if (st_sec_reg >= bdc_mmss_to_sec(i_slow_start_min, i_slow_start_sec)) begin
          state_next = ST_FULL;
        end
      end
      ST_FULL: begin
        // Full flow until the prestop point
        if (deliv_reg >= prestop_pt) begin
          state_next = ST_PREST;
        end
      end
      ST_PREST: begin
        // Trickle until the end of batch
      end
      ST_DONE: begin
        // Flow that still arrives after the valves close is the overrun
        if (timed_out && i_overrun_compensation) begin
          comp_next = ovr_cnt_reg;
        end
        if (i_auto_restart && i_batch_controller_config && !i_key_run && !i_key_reset &&
            st_sec_reg >= bdc_mmss_to_sec(i_restart_min, i_restart_sec)) begin
          state_next = ST_SLOW;
          deliv_next = '0;
          need_reset_next = 1'b0;
          done_next = 1'b0;
          idle_sec_next = '0;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase

    // End, timeout and stop of a running batch; end of batch has priority
    if (run_state) begin
      if (deliv_next >= target) begin
        state_next = ST_DONE;
        need_reset_next = 1'b1;
        done_next = 1'b1;
        ovr_cnt_next = '0;
        idle_sec_next = '0;
      end else if (timed_out) begin
        state_next = ST_IDLE;
        tout_next = 1'b1;
      end else if (i_key_stop) begin
        state_next = ST_IDLE;
      end
    end

    // Compensation is dropped when it cannot take effect
    if (!i_overrun_compensation || i_timeout_sec == `BDC_TIMEOUT_OFF) begin
      comp_next = '0;
    end

    // New state restarts its seconds count on a fresh divider phase
    if (state_next != state_reg) begin
      st_sec_next = '0;
      restart_next = 1'b1;
    end

    // Relays: batch profile, or rate alarms in totaliser configuration
    if (i_batch_controller_config) begin
      r1_next = (state_next == ST_SLOW) || (state_next == ST_FULL) ||
                (state_next == ST_PREST);
      r2_next = (state_next == ST_FULL);
    end else begin
      r1_next = hi_alarm;
      r2_next = lo_alarm;
    end

    // Running flag follows the next state so it changes together with the relays
    run_next = (state_next == ST_SLOW) || (state_next == ST_FULL) || (state_next == ST_PREST);

    // Displayed total follows the count direction
    total_next = i_count_down ? bdc_sat_sub(qty_next, deliv_next) : deliv_next;
  end

  // Register all state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      pulse_prev_reg <= 1'b0;
      qty_reg <= '0;
      deliv_reg <= '0;
      ovr_cnt_reg <= '0;
      comp_reg <= '0;
      st_sec_reg <= '0;
      idle_sec_reg <= '0;
      need_reset_reg <= 1'b0;
      restart_reg <= 1'b0;
      r1_reg <= 1'b0;
      r2_reg <= 1'b0;
      total_reg <= '0;
      done_reg <= 1'b0;
      tout_reg <= 1'b0;
      rej_reg <= 1'b0;
      refused_reg <= 1'b0;
      run_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pulse_prev_reg <= pulse_prev_next;
      qty_reg <= qty_next;
      deliv_reg <= deliv_next;
      ovr_cnt_reg <= ovr_cnt_next;
      comp_reg <= comp_next;
      st_sec_reg <= st_sec_next;
      idle_sec_reg <= idle_sec_next;
      need_reset_reg <= need_reset_next;
      restart_reg <= restart_next;
      r1_reg <= r1_next;
      r2_reg <= r2_next;
      total_reg <= total_next;
      done_reg <= done_next;
      tout_reg <= tout_next;
      rej_reg <= rej_next;
      refused_reg <= refused_next;
      run_reg <= run_next;
    end
  end

  // Outputs straight from registers
  assign o_relay1 = r1_reg;
  assign o_relay2 = r2_reg;
  assign o_batch_qty = qty_reg;
  assign o_batch_total = total_reg;
  assign o_overrun = comp_reg;
  assign o_running = run_reg;
  assign o_batch_done = done_reg;
  assign o_timeout_flag = tout_reg;
  assign o_qty_reject = rej_reg;
  assign o_run_refused = refused_reg;

endmodule : bdc_batch_ctrl

// file: rtl/bdc_pkg.sv
// Types and shared arithmetic of the batch dispense controller.
// Assumes bdc_regs.svh for widths.
`include "bdc_regs.svh"

package bdc_pkg;

  // Quantity and seconds types
  typedef logic [`BDC_QTY_W-1:0] bdc_qty_t;
  typedef logic [`BDC_SEC_W-1:0] bdc_sec_t;

  // Batch sequence states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SLOW = 5'h02,
    ST_FULL = 5'h04,
    ST_PREST = 5'h08,
    ST_DONE = 5'h10
  } bdc_state_t;

  // Minutes and seconds setting to plain seconds
  function automatic bdc_sec_t bdc_mmss_to_sec(input logic [`BDC_MIN_W-1:0] mins,
                                               input logic [`BDC_SS_W-1:0] secs);
    bdc_sec_t m;
    m = bdc_sec_t'(mins);
    return bdc_sec_t'(m * `BDC_SEC_PER_MIN) + bdc_sec_t'(secs);
  endfunction : bdc_mmss_to_sec

  // Subtraction that stops at zero instead of wrapping
  function automatic bdc_qty_t bdc_sat_sub(input bdc_qty_t a, input bdc_qty_t b);
    return (a > b) ? bdc_qty_t'(a - b) : bdc_qty_t'(0);
  endfunction : bdc_sat_sub

endpackage : bdc_pkg

// file: rtl/bdc_rate_alarm.sv
// Flow rate measurement in pulses per second and high/low rate alarms.
// Assumes a one-cycle flow pulse and a seconds tick from the shared divider.
`timescale 1ns/1ps

module bdc_rate_alarm
  import bdc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Measurement inputs
  input wire logic i_pulse,
  input wire logic i_enable,
  input wire bdc_qty_t i_high_rate_alarm_point,
  input wire bdc_qty_t i_low_rate_alarm_point,
  bdc_tick_if.watch tick,
  // Alarm levels
  output logic o_high_alarm,
  output logic o_low_alarm,
  output bdc_qty_t o_rate
);

  bdc_qty_t win_reg, win_next;   // Pulses in the open one-second window
  bdc_qty_t rate_reg, rate_next; // Pulses in the last whole window
  logic hi_reg, hi_next;
  logic lo_reg, lo_next;

  // Window count and compare; rate is refreshed once a second, so alarms lag up to 1 s
  always_comb begin
    win_next = win_reg;
    rate_next = rate_reg;
    if (tick.sec_tick) begin
      rate_next = win_reg;
      win_next = bdc_qty_t'(i_pulse);
    end else if (i_pulse && win_reg != '1) begin
      win_next = win_reg + 1'b1;
    end
    hi_next = i_enable && (rate_reg > i_high_rate_alarm_point);
    lo_next = i_enable && (rate_reg < i_low_rate_alarm_point);
  end

  // Register window, rate and alarms
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win_reg <= '0;
      rate_reg <= '0;
      hi_reg <= 1'b0;
      lo_reg <= 1'b0;
    end else begin
      win_reg <= win_next;
      rate_reg <= rate_next;
      hi_reg <= hi_next;
      lo_reg <= lo_next;
    end
  end

  assign o_high_alarm = hi_reg;
  assign o_low_alarm = lo_reg;
  assign o_rate = rate_reg;

endmodule : bdc_rate_alarm

// file: rtl/bdc_regs.svh
// Constants of the batch dispense controller: widths, fixed values and timing counts.
// Assumes a single 50 MHz clock; included by bare name where needed.
`ifndef BDC_REGS_SVH
`define BDC_REGS_SVH

// Data widths
`define BDC_QTY_W 24
`define BDC_SEC_W 16
`define BDC_MIN_W 7
`define BDC_SS_W 6
`define BDC_TOUT_W 8
`define BDC_DIV_W 26

// Special setting values
`define BDC_NO_LIMIT 24'h000000
`define BDC_TIMEOUT_OFF 8'h00
`define BDC_SEC_PER_MIN 16'h003C

// Timing: one second, in ns, and the clock period it is counted in
`define BDC_CLK_PERIOD_NS 20
`define BDC_ONE_SEC_NS 1000000000
`define BDC_CYC_PER_SEC (`BDC_ONE_SEC_NS / `BDC_CLK_PERIOD_NS)

`endif

// file: rtl/bdc_sec_timer.sv
// Seconds divider: one-cycle tick every CYC_PER_SEC clocks, re-phased on restart.
// Assumes the clock runs at the rate behind CYC_PER_SEC.
`timescale 1ns/1ps
`include "bdc_regs.svh"

module bdc_sec_timer #(
  parameter int CYC_PER_SEC = `BDC_CYC_PER_SEC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Tick carrier
  bdc_tick_if.timer tick
);

  logic [`BDC_DIV_W-1:0] cnt_reg; // Cycles within the current second
  logic [`BDC_DIV_W-1:0] cnt_next;
  logic tick_reg; // Registered tick
  logic tick_next;

  // Next divider value; restart wins so a new phase starts a full second
  always_comb begin
    cnt_next = cnt_reg + 1'b1;
    tick_next = 1'b0;
    if (tick.restart) begin
      cnt_next = '0;
    end else if (cnt_reg == `BDC_DIV_W'(CYC_PER_SEC - 1)) begin
      cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  // Register the divider
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick.sec_tick = tick_reg;

endmodule : bdc_sec_timer

// file: rtl/bdc_tick_if.sv
// Seconds tick carrier between the controller and its helper modules.
// Assumes one clock domain; restart and tick are one-cycle pulses.
`timescale 1ns/1ps

interface bdc_tick_if;
  logic restart;  // Re-phase the seconds divider
  logic sec_tick; // One pulse per second
  modport timer (input restart, output sec_tick);
  modport user (output restart, input sec_tick);
  modport watch (input sec_tick);
endinterface : bdc_tick_if

// file: tb/bdc_batch_ctrl_props.sv
// Port checker of the batch dispense controller.
// Assumes bdc_pkg is compiled first; bound to every bdc_batch_ctrl.
`timescale 1ns/1ps
`include "bdc_regs.svh"

module bdc_batch_ctrl_props
  import bdc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Watched inputs
  input wire logic i_key_run,
  input wire logic i_key_reset,
  input wire logic i_batch_controller_config,
  input wire logic i_qty_load,
  input wire bdc_qty_t i_qty,
  input wire bdc_qty_t i_max_batch_size,
  input wire logic [`BDC_TOUT_W-1:0] i_timeout_sec,
  input wire logic i_overrun_compensation,
  input wire logic i_auto_reset,
  // Watched outputs
  input wire logic o_relay1,
  input wire logic o_relay2,
  input wire bdc_qty_t o_batch_qty,
  input wire bdc_qty_t o_overrun,
  input wire logic o_running,
  input wire logic o_batch_done,
  input wire logic o_timeout_flag,
  input wire logic o_qty_reject,
  input wire logic o_run_refused
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Run key taken in batch mode while stopped; reset key wins, so excluded
  logic run_ok;
  // Load taken in batch mode while stopped
  logic load_ok;
  assign run_ok = i_batch_controller_config && i_key_run && !i_key_reset && !o_running;
  assign load_ok = i_batch_controller_config && i_qty_load && !o_running;

  chk_run_starts: assert property (run_ok && !o_batch_done && o_batch_qty != 24'h000000
    |=> o_running && o_relay1 && !o_relay2) else $error("run did not start slow");
  chk_run_refused: assert property (run_ok && o_batch_done && !i_auto_reset
    |=> o_run_refused && !o_running) else $error("run not refused");
  chk_auto_reset: assert property (run_ok && o_batch_done && i_auto_reset
    |=> o_running && !o_batch_done) else $error("auto reset start failed");
  chk_qty_reject: assert property (load_ok && i_max_batch_size != 24'h000000
    && i_qty > i_max_batch_size |=> o_qty_reject && $stable(o_batch_qty))
    else $error("oversize quantity kept");
  chk_qty_accept: assert property (load_ok && (i_max_batch_size == 24'h000000
    || i_qty <= i_max_batch_size) |=> !o_qty_reject && o_batch_qty == $past(i_qty))
    else $error("quantity not loaded");
  chk_total_idle: assert property (!i_batch_controller_config && !o_running
    |=> !o_running && $stable(o_batch_qty)) else $error("totaliser took batch entry");
  chk_end_release: assert property ($rose(o_batch_done)
    |-> !o_relay1 && !o_relay2 && !o_running) else $error("relays held at end");
  chk_relay2_gated: assert property (o_relay2 && i_batch_controller_config
    |-> o_relay1 && o_running) else $error("relay 2 outside run");
  chk_timeout_cause: assert property ($rose(o_timeout_flag)
    |-> $past(i_timeout_sec) != 8'h00 && !o_running) else $error("bad timeout");
  chk_overrun_gate: assert property (i_timeout_sec == 8'h00 || !i_overrun_compensation
    |=> o_overrun == 24'h000000) else $error("overrun not cleared");
endmodule : bdc_batch_ctrl_props

bind bdc_batch_ctrl bdc_batch_ctrl_props i_props (.i_clk, .i_rst_n, .i_key_run, .i_key_reset,
  .i_batch_controller_config, .i_qty_load, .i_qty, .i_max_batch_size, .i_timeout_sec,
  .i_overrun_compensation, .i_auto_reset, .o_relay1, .o_relay2, .o_batch_qty, .o_overrun,
  .o_running, .o_batch_done, .o_timeout_flag, .o_qty_reject, .o_run_refused);

// file: tb/bdc_batch_ctrl_test.sv
// Self-checking bench of the batch dispense controller.
// Assumes the flow model and the bound checker are compiled before it.
`timescale 1ns/1ps

module bdc_batch_ctrl_test;
  import bdc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_flow_pulse, i_key_run, i_key_stop, i_key_reset, i_batch_controller_config;
  logic i_qty_load, i_auto_restart, i_count_down, i_overrun_compensation, i_auto_reset;
  bdc_qty_t i_qty, i_max_batch_size, i_prestop_qty, i_high_rate_alarm_point;
  bdc_qty_t i_low_rate_alarm_point, o_batch_qty, o_batch_total, o_overrun;
  logic [7:0] i_timeout_sec, gap, lag;
  logic o_relay1, o_relay2, o_running, o_batch_done, o_timeout_flag, o_qty_reject;
  logic o_run_refused, on, free;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0; // Watchdog count
  int n_over = 0; // Pulses after batch end
  int n_run = 0; // Pulses while running
  int n; // Cycles spent in the last wait

  always #10 i_clk = ~i_clk;

  // Twenty cycles a second keeps every timed phase short
  bdc_batch_ctrl #(.CYC_PER_SEC(20)) i_dut (.i_clk, .i_rst_n, .i_flow_pulse, .i_key_run,
    .i_key_stop, .i_key_reset, .i_batch_controller_config, .i_qty_load, .i_qty,
    .i_max_batch_size, .i_auto_restart, .i_restart_min(7'h00), .i_restart_sec(6'h01),
    .i_slow_start_min(7'h00), .i_slow_start_sec(6'h01), .i_prestop_qty, .i_count_down,
    .i_timeout_sec, .i_overrun_compensation, .i_auto_reset, .i_high_rate_alarm_point,
    .i_low_rate_alarm_point, .o_relay1, .o_relay2, .o_batch_qty, .o_batch_total,
    .o_overrun, .o_running, .o_batch_done, .o_timeout_flag, .o_qty_reject, .o_run_refused);

  // Relay 1 is the valve; in totaliser mode the line flows freely
  bdc_flow_model i_flow (.i_clk, .i_rst_n, .i_valve(o_relay1 | free), .i_on(on),
    .i_gap(gap), .i_lag(lag), .o_pulse(i_flow_pulse));

  // Pulse tallies sampled like the design samples them
  always @(posedge i_clk) begin
    cyc++;
    if (i_flow_pulse && o_batch_done) n_over++;
    if (i_flow_pulse && o_running) n_run++;
    if (cyc == 5000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : tick

  // One-cycle key press: 0 run, 1 stop, 2 reset
  task automatic press(input int k);
    @(posedge i_clk);
    case (k)
      0: i_key_run <= 1'b1;
      1: i_key_stop <= 1'b1;
      default: i_key_reset <= 1'b1;
    endcase
    @(posedge i_clk);
    {i_key_run, i_key_stop, i_key_reset} <= 3'b000;
    #1;
  endtask : press

  task automatic load_qty(input bdc_qty_t mx, input bdc_qty_t q, input logic rj,
                          input bdc_qty_t exp);
    @(posedge i_clk);
    i_max_batch_size <= mx;
    i_qty <= q;
    i_qty_load <= 1'b1;
    @(posedge i_clk);
    i_qty_load <= 1'b0;
    #1;
    chk(o_qty_reject, rj, "reject pulse");
    chk(o_batch_qty, exp, "batch quantity");
  endtask : load_qty

  function automatic logic pick(input int k);
    case (k)
      0: return o_relay2;
      1: return o_batch_done;
      2: return o_running;
      default: return o_timeout_flag;
    endcase
  endfunction : pick

  // Bounded wait for an output level; n keeps the cycles taken
  task automatic wait_for(input int k, input logic v, input int lim);
    n = 0;
    while (pick(k) !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk(pick(k), v, "wait expired");
  endtask : wait_for

  initial begin
    {i_key_run, i_key_stop, i_key_reset, i_qty_load, i_count_down} = '0;
    {i_auto_restart, i_overrun_compensation, i_auto_reset, free, lag} = '0;
    {i_batch_controller_config, on} = 2'b11;
    {i_qty, i_max_batch_size} = '0;
    i_prestop_qty = 24'h000003;
    i_high_rate_alarm_point = 24'h000008;
    i_low_rate_alarm_point = 24'h000002;
    i_timeout_sec = 8'h00;
    gap = 8'h06;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    load_qty(24'h000064, 24'h000065, 1'b1, 24'h000000);
    load_qty(24'h000064, 24'h000064, 1'b0, 24'h000064);
    load_qty(24'h000000, 24'h000200, 1'b0, 24'h000200);
    load_qty(24'h000000, 24'h00000A, 1'b0, 24'h00000A);
    // Count-up batch: slow start, prestop, end
    press(0);
    wait_for(0, 1'b1, 40);
    chk(24'(n >= 17 && n <= 23), 24'h000001, "slow start time");
    wait_for(0, 1'b0, 80);
    tick(2);
    chk(o_batch_total, 24'h000007, "prestop point");
    wait_for(1, 1'b1, 60);
    tick(2);
    chk(o_batch_total, 24'h00000A, "count up total");
    chk({o_relay1, o_relay2, o_running}, 3'b000, "relays at end");
    // Finished batch needs a manual reset
    press(0);
    chk({o_run_refused, o_running}, 2'b10, "run after end");
    @(posedge i_clk);
    i_count_down <= 1'b1;
    press(2);
    press(0);
    chk(o_batch_total, 24'h00000A, "count down start");
    wait_for(1, 1'b1, 200);
    tick(2);
    chk(o_batch_total, 24'h000000, "count down end");
    // Auto reset: one run press clears and starts
    @(posedge i_clk);
    i_auto_reset <= 1'b1;
    press(0);
    tick(1);
    chk({o_running, o_batch_done}, 2'b10, "auto reset run");
    chk(o_batch_total, 24'h00000A, "total cleared");
    // Stalled flow: ignored with timeout off, stops the batch with it on
    @(posedge i_clk);
    on <= 1'b0;
    tick(100);
    chk({o_running, o_timeout_flag}, 2'b10, "timeout off");
    press(1);
    @(posedge i_clk);
    i_timeout_sec <= 8'h01;
    press(0);
    wait_for(3, 1'b1, 80);
    chk({o_running, o_relay1}, 2'b00, "timeout stop");
    @(posedge i_clk);
    on <= 1'b1;
    press(0);
    chk(o_timeout_flag, 1'b0, "flag cleared");
    wait_for(1, 1'b1, 200);
    // Overrun from a slow valve is measured, then taken off the next batch
    @(posedge i_clk);
    {i_overrun_compensation, i_count_down, lag} <= {2'b10, 8'h0E};
    press(0);
    wait_for(1, 1'b1, 200);
    n_over = 0;
    tick(80);
    chk(o_overrun, 24'(n_over), "overrun measured");
    @(posedge i_clk);
    {i_auto_restart, lag} <= {1'b1, 8'h00};
    n_run = 0;
    press(0);
    wait_for(1, 1'b1, 200);
    chk(24'(n_run), 24'(10 - n_over), "compensated batch");
    wait_for(2, 1'b1, 40);
    chk(24'(n >= 17 && n <= 24), 24'h000001, "restart delay");
    @(posedge i_clk);
    {i_auto_restart, i_overrun_compensation, i_timeout_sec} <= '0;
    press(1);
    // Rate totaliser: batch entry ignored, relays follow the rate
    @(posedge i_clk);
    {i_batch_controller_config, free, gap} <= {2'b01, 8'h02};
    press(0);
    chk(o_running, 1'b0, "totaliser run");
    load_qty(24'h000000, 24'h000005, 1'b0, 24'h00000A);
    tick(60);
    chk({o_relay1, o_relay2}, 2'b10, "high rate");
    gap <= 8'h04;
    tick(60);
    chk({o_relay1, o_relay2}, 2'b00, "mid rate");
    on <= 1'b0;
    tick(60);
    chk({o_relay1, o_relay2}, 2'b01, "low rate");
    summarize();
  end
endmodule : bdc_batch_ctrl_test

// file: tb/bdc_flow_model.sv
// Flowmeter behind a relay-driven valve: pulses while the line flows.
// Assumes one clock; a gap of two or more keeps each pulse one cycle.
`timescale 1ns/1ps

module bdc_flow_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Valve and bench controls
  input wire logic i_valve,
  input wire logic i_on,
  input wire logic [7:0] i_gap,
  input wire logic [7:0] i_lag,
  // Meter output
  output logic o_pulse
);
  int cnt; // Cycles into the current pulse gap
  int hold; // Cycles the line still runs after the valve shuts
  logic flow; // Line is flowing this cycle
  // A slow valve lets product run on after closing, which makes overrun
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt = 0;
      hold = 0;
      o_pulse <= 1'b0;
    end else begin
      hold = i_valve ? int'(i_lag) : (hold > 0 ? hold - 1 : 0);
      flow = i_on && (i_valve || hold > 0);
      cnt = flow ? (cnt + 1) % int'(i_gap) : 0;
      o_pulse <= flow && cnt == 1; // Idle line stays low
    end
  end
endmodule : bdc_flow_model
